// ===== cscr_pkg.sv
/*
  constants, field positions and state codes for the converter serial
  control register bank (offsets 0x00 to 0x08).
  assumes a host that frames 16-bit instructions followed by data bytes.
*/
package cscr_pkg;

  localparam logic [12:0] ADDR_PORT_SETUP  = 13'h0000;
  localparam logic [12:0] ADDR_PART_ID     = 13'h0001;
  localparam logic [12:0] ADDR_GRADE_ID    = 13'h0002;
  localparam logic [12:0] ADDR_CHAN_HIGH   = 13'h0004;
  localparam logic [12:0] ADDR_CHAN_LOW    = 13'h0005;
  localparam logic [12:0] ADDR_MODES       = 13'h0008;

  localparam logic [7:0]  RST_PORT_SETUP   = 8'h18;
  localparam logic [7:0]  RST_CHAN_SEL     = 8'hFF;
  localparam logic [7:0]  RST_MODES        = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED      = 8'h00;

  // port setup fields and their mirrors in the low nibble
  localparam int          PS_SDO_BIT       = 7;
  localparam int          PS_LSB_BIT       = 6;
  localparam int          PS_SRST_BIT      = 5;
  localparam int          PS_SRST_MIR      = 2;
  localparam int          PS_LSB_MIR       = 1;
  localparam int          PS_SDO_MIR       = 0;
  localparam logic [1:0]  PS_FIXED_BITS    = 2'h3;

  // modes fields
  localparam int          MD_EXT_EN_BIT    = 7;
  localparam int          MD_EXT_MODE_LSB  = 5;
  localparam int          MD_BYPASS_BIT    = 3;
  localparam int          MD_INT_MODE_LSB  = 0;

  typedef enum logic [2:0] {
    IPD_NORMAL  = 3'h0,
    IPD_FULL    = 3'h1,
    IPD_STANDBY = 3'h2,
    IPD_CORE    = 3'h4,
    IPD_AFE     = 3'h5,
    IPD_RSVD    = 3'h6
  } cscr_ipd_e;

  typedef enum logic [1:0] {
    EPD_FULL    = 2'h0,
    EPD_STANDBY = 2'h1,
    EPD_OUT_OFF = 2'h2
  } cscr_epd_e;

  // serial frame
  localparam logic [4:0]  INSTR_LAST_BIT   = 5'h0F;
  localparam logic [2:0]  DATA_LAST_BIT    = 3'h7;
  localparam int          INSTR_RW_BIT     = 15;

  typedef enum logic [1:0] {
    FR_INSTR = 2'h0,
    FR_WRITE = 2'h1,
    FR_READ  = 2'h2
  } cscr_frame_e;

endpackage

// ===== cscr_pin_sync.sv
/*
  two-flop synchroniser for one pin with rise and fall pulses.
  assumes the pin changes slower than a few clk_sys periods.
*/
module cscr_pin_sync #(
  parameter bit INIT = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // meta_q feeds sync_q only
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
      last_q <= INIT;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;

endmodule

// ===== cscr_regs.sv
/*
  serial port register bank: port setup, identifiers, channel selects and
  power modes, reached over the serial pins and oversampled by clk_sys.
  assumes the serial clock runs below one eighth of clk_sys.
*/
module cscr_regs #(
  parameter logic [7:0] PART_ID  = 8'h5A,  // arbitrary value
  parameter logic [7:0] GRADE_ID = 8'h01   // arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       sclk_pin,
  input  wire logic       csb_n_pin,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  output logic            sdo_out,
  output logic            sdo_oe,
  input  wire logic       pwdn_pin,
  output logic [7:0]      conv_chan_en,
  output logic [7:0]      aux_chan_en,
  output logic            lsb_first,
  output logic            function_bypass,
  output logic            pwr_full_down,
  output logic            pwr_standby,
  output logic            pwr_core_down,
  output logic            pwr_afe_down,
  output logic            outputs_disabled
);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = v[7 - i];
    return r;
  endfunction

  logic sclk_rise, sclk_fall, csb_n_lvl, sdio_lvl, pwdn_lvl;

  cscr_pin_sync #(.INIT(1'b0)) u_sclk (
    .clk_sys (clk_sys), .srst (srst), .pin (sclk_pin),
    .level (), .rise (sclk_rise), .fall (sclk_fall));
  cscr_pin_sync #(.INIT(1'b1)) u_csb (
    .clk_sys (clk_sys), .srst (srst), .pin (csb_n_pin),
    .level (csb_n_lvl), .rise (), .fall ());
  cscr_pin_sync #(.INIT(1'b0)) u_sdio (
    .clk_sys (clk_sys), .srst (srst), .pin (sdio_in),
    .level (sdio_lvl), .rise (), .fall ());
  cscr_pin_sync #(.INIT(1'b0)) u_pwdn (
    .clk_sys (clk_sys), .srst (srst), .pin (pwdn_pin),
    .level (pwdn_lvl), .rise (), .fall ());

  // control registers
  logic                 sdo_en_q;
  logic                 lsb_q;
  logic                 soft_rst_q;
  logic [7:0]           chan_hi_q;
  logic [7:0]           chan_lo_q;
  logic [7:0]           modes_q;

  // frame state
  cscr_pkg::cscr_frame_e state_q;
  logic [4:0]           bit_cnt_q;
  logic [14:0]          shift_q;
  logic [12:0]          addr_q;
  logic [7:0]           rd_shift_q;

  // output flops
  logic                 sdio_out_q, sdio_oe_q, sdo_out_q, sdo_oe_q;
  logic [7:0]           conv_en_q, aux_en_q;
  logic                 full_q, stby_q, core_q, afe_q, outoff_q, byp_q;

  wire        active     = ~csb_n_lvl;
  wire [15:0] in_shift   = {shift_q, sdio_lvl};
  wire [15:0] instr_word = lsb_q ? {rev8(in_shift[7:0]), rev8(in_shift[15:8])}
                                 : in_shift;
  wire        instr_done = active & sclk_rise & (state_q == cscr_pkg::FR_INSTR)
                           & (bit_cnt_q == cscr_pkg::INSTR_LAST_BIT);
  wire        byte_done  = active & sclk_rise & (state_q != cscr_pkg::FR_INSTR)
                           & (bit_cnt_q[2:0] == cscr_pkg::DATA_LAST_BIT);
  wire [7:0]  wr_data    = lsb_q ? rev8(in_shift[7:0]) : in_shift[7:0];
  wire        wr_stb     = byte_done & (state_q == cscr_pkg::FR_WRITE);
  // streaming walks down in msb-first order and up in lsb-first order
  wire [12:0] next_addr  = lsb_q ? addr_q + 13'h0001 : addr_q - 13'h0001;
  wire [12:0] rd_addr    = instr_done ? instr_word[12:0] : next_addr;
  wire        load_rd    = (instr_done & instr_word[cscr_pkg::INSTR_RW_BIT])
                           | (byte_done & (state_q == cscr_pkg::FR_READ));

  // reserved bits 4:3 read back set, soft reset reads its live state
  wire [7:0]  port_rd    = {sdo_en_q, lsb_q, soft_rst_q,
                            cscr_pkg::PS_FIXED_BITS,
                            soft_rst_q, lsb_q, sdo_en_q};

  logic [7:0] rd_value;
  always_comb
  begin
    case (rd_addr)
      cscr_pkg::ADDR_PORT_SETUP: rd_value = port_rd;
      cscr_pkg::ADDR_PART_ID:    rd_value = PART_ID;
      cscr_pkg::ADDR_GRADE_ID:   rd_value = GRADE_ID;
      cscr_pkg::ADDR_CHAN_HIGH:  rd_value = chan_hi_q;
      cscr_pkg::ADDR_CHAN_LOW:   rd_value = chan_lo_q;
      cscr_pkg::ADDR_MODES:      rd_value = modes_q;
      default:                   rd_value = cscr_pkg::RD_UNMAPPED;
    endcase
  end

  // either copy of a mirrored flag takes effect, so a value shifted in
  // the wrong order still lands correctly
  wire ps_wr       = wr_stb & (addr_q == cscr_pkg::ADDR_PORT_SETUP);
  wire ps_soft_rst = wr_data[cscr_pkg::PS_SRST_BIT]
                     | wr_data[cscr_pkg::PS_SRST_MIR];
  wire ps_lsb      = wr_data[cscr_pkg::PS_LSB_BIT]
                     | wr_data[cscr_pkg::PS_LSB_MIR];
  wire ps_sdo      = wr_data[cscr_pkg::PS_SDO_BIT]
                     | wr_data[cscr_pkg::PS_SDO_MIR];
  wire regs_rst    = srst | soft_rst_q;

  always_ff @(posedge clk_sys)
  begin
    if (regs_rst)
    begin
      sdo_en_q  <= cscr_pkg::RST_PORT_SETUP[cscr_pkg::PS_SDO_BIT];
      lsb_q     <= cscr_pkg::RST_PORT_SETUP[cscr_pkg::PS_LSB_BIT];
      chan_hi_q <= cscr_pkg::RST_CHAN_SEL;
      chan_lo_q <= cscr_pkg::RST_CHAN_SEL;
      modes_q   <= cscr_pkg::RST_MODES;
    end
    else if (wr_stb)
    begin
      case (addr_q)
        cscr_pkg::ADDR_PORT_SETUP:
        begin
          sdo_en_q <= ps_sdo;
          lsb_q    <= ps_lsb;
        end
        cscr_pkg::ADDR_CHAN_HIGH: chan_hi_q <= wr_data;
        cscr_pkg::ADDR_CHAN_LOW:  chan_lo_q <= wr_data;
        cscr_pkg::ADDR_MODES:     modes_q   <= wr_data;
        default:                  modes_q   <= modes_q;
      endcase
    end
  end

  // one-cycle pulse: next cycle restores defaults and drops the bit
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= ps_wr & ps_soft_rst & ~soft_rst_q;
  end

  // frame engine; instruction width bits are ignored and bytes stream
  // until chip select rises
  always_ff @(posedge clk_sys)
  begin
    if (srst | ~active)
    begin
      state_q   <= cscr_pkg::FR_INSTR;
      bit_cnt_q <= 5'h00;
      shift_q   <= 15'h0000;
      addr_q    <= 13'h0000;
    end
    else if (sclk_rise)
    begin
      shift_q   <= in_shift[14:0];
      bit_cnt_q <= instr_done ? 5'h00 : bit_cnt_q + 5'h01;
      if (instr_done)
      begin
        addr_q  <= instr_word[12:0];
        state_q <= instr_word[cscr_pkg::INSTR_RW_BIT] ? cscr_pkg::FR_READ
                                                       : cscr_pkg::FR_WRITE;
      end
      else if (byte_done)
        addr_q  <= next_addr;
    end
  end

  // read data leaves on falling serial clock edges
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rd_shift_q <= 8'h00;
      sdio_out_q <= 1'b0;
      sdo_out_q  <= 1'b0;
    end
    else if (load_rd)
      rd_shift_q <= lsb_q ? rev8(rd_value) : rd_value;
    else if (sclk_fall & active & (state_q == cscr_pkg::FR_READ))
    begin
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      sdio_out_q <= rd_shift_q[7];
      sdo_out_q  <= rd_shift_q[7];
    end
  end

  wire reading = active & (state_q == cscr_pkg::FR_READ);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sdio_oe_q <= 1'b0;
      sdo_oe_q  <= 1'b0;
    end
    else
    begin
      sdio_oe_q <= reading & ~sdo_en_q;
      sdo_oe_q  <= reading & sdo_en_q;
    end
  end

  // power state decode; external pin overrides the internal field
  wire [2:0] int_mode = modes_q[cscr_pkg::MD_INT_MODE_LSB +: 3];
  wire [1:0] ext_mode = modes_q[cscr_pkg::MD_EXT_MODE_LSB +: 2];
  wire       ext_act  = modes_q[cscr_pkg::MD_EXT_EN_BIT] & pwdn_lvl;
  wire       full_d   = ext_act ? (ext_mode == cscr_pkg::EPD_FULL)
                                : (int_mode == cscr_pkg::IPD_FULL);
  wire       stby_d   = ext_act ? (ext_mode == cscr_pkg::EPD_STANDBY)
                                : (int_mode == cscr_pkg::IPD_STANDBY);
  wire       core_d   = ~ext_act & (int_mode == cscr_pkg::IPD_CORE);
  wire       afe_d    = ~ext_act & (int_mode == cscr_pkg::IPD_AFE);
  wire       outoff_d = ext_act & (ext_mode == cscr_pkg::EPD_OUT_OFF);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      full_q    <= 1'b0;
      stby_q    <= 1'b0;
      core_q    <= 1'b0;
      afe_q     <= 1'b0;
      outoff_q  <= 1'b0;
      byp_q     <= 1'b0;
      conv_en_q <= cscr_pkg::RST_CHAN_SEL;
      aux_en_q  <= cscr_pkg::RST_CHAN_SEL;
    end
    else
    begin
      full_q    <= full_d;
      stby_q    <= stby_d;
      core_q    <= core_d;
      afe_q     <= afe_d;
      outoff_q  <= outoff_d;
      byp_q     <= modes_q[cscr_pkg::MD_BYPASS_BIT];
      conv_en_q <= {chan_hi_q[3:0], chan_lo_q[3:0]};
      aux_en_q  <= {chan_hi_q[7:4], chan_lo_q[7:4]};
    end
  end

  assign sdio_out         = sdio_out_q;
  assign sdio_oe          = sdio_oe_q;
  assign sdo_out          = sdo_out_q;
  assign sdo_oe           = sdo_oe_q;
  assign conv_chan_en     = conv_en_q;
  assign aux_chan_en      = aux_en_q;
  assign lsb_first        = lsb_q;
  assign function_bypass  = byp_q;
  assign pwr_full_down    = full_q;
  assign pwr_standby      = stby_q;
  assign pwr_core_down    = core_q;
  assign pwr_afe_down     = afe_q;
  assign outputs_disabled = outoff_q;

  sequence s_soft_write;
    ps_wr & ps_soft_rst & ~soft_rst_q;
  endsequence

  sequence s_defaults;
    (port_rd == cscr_pkg::RST_PORT_SETUP) & (chan_hi_q == 8'hFF)
    & (chan_lo_q == 8'hFF) & (modes_q == 8'h00);
  endsequence

  a_port_reset_val: assert property (
    @(posedge clk_sys) $fell(srst) |-> port_rd == 8'h18)
    else $error("port setup not 18h after reset");

  a_chan_reset_all: assert property (
    @(posedge clk_sys)
    $fell(srst) |-> ##1 (conv_en_q == 8'hFF) && (aux_en_q == 8'hFF))
    else $error("channel enables not all set after reset");

  // watch the loaded shift byte, so a broken load or order path trips
  a_part_id_fixed: assert property (
    @(posedge clk_sys) disable iff (srst)
    load_rd && rd_addr == cscr_pkg::ADDR_PART_ID
    |=> rd_shift_q == (lsb_q ? rev8(PART_ID) : PART_ID))
    else $error("part identifier read wrong");

  a_grade_id_fixed: assert property (
    @(posedge clk_sys) disable iff (srst)
    load_rd && rd_addr == cscr_pkg::ADDR_GRADE_ID
    |=> rd_shift_q == (lsb_q ? rev8(GRADE_ID) : GRADE_ID))
    else $error("grade identifier read wrong");

  a_low_sel_map: assert property (
    @(posedge clk_sys) disable iff (srst)
    wr_stb && addr_q == cscr_pkg::ADDR_CHAN_LOW |-> ##2
    conv_en_q[3:0] == $past(wr_data[3:0], 2)
    && aux_en_q[3:0] == $past(wr_data[7:4], 2))
    else $error("low channel select not applied");

  a_high_sel_map: assert property (
    @(posedge clk_sys) disable iff (srst)
    wr_stb && addr_q == cscr_pkg::ADDR_CHAN_HIGH |-> ##2
    conv_en_q[7:4] == $past(wr_data[3:0], 2)
    && aux_en_q[7:4] == $past(wr_data[7:4], 2))
    else $error("high channel select not applied");

  a_int_pd_decode: assert property (
    @(posedge clk_sys) disable iff (srst)
    !ext_act && int_mode == 3'h5 |=> afe_q && !core_q && !full_q)
    else $error("internal power-down decode wrong");

  a_ext_pd_decode: assert property (
    @(posedge clk_sys) disable iff (srst)
    ext_act && ext_mode == 2'h2 |=> outoff_q && !full_q && !stby_q)
    else $error("external power-down decode wrong");

  a_fixed_bits_set: assert property (
    @(posedge clk_sys) disable iff (srst)
    load_rd && rd_addr == cscr_pkg::ADDR_PORT_SETUP
    |=> rd_shift_q[4:3] == 2'h3)
    else $error("fixed port setup bits cleared");

  a_soft_rst_seq: assert property (
    @(posedge clk_sys) disable iff (srst)
    s_soft_write |=> soft_rst_q ##1 ((!soft_rst_q) and s_defaults))
    else $error("soft reset did not restore defaults and clear");

endmodule

// ===== cscr_host.sv
/*
  host model for the serial control port: one 16-bit instruction and one
  data byte per frame, mode 0, six clk_sys periods per sclk phase.
  assumes the bench calls xfer from one process at a time.
*/
module cscr_host (
  input  wire logic       clk_sys,
  output logic            sclk_pin,
  output logic            csb_n_pin,
  output logic            sdio_in,
  input  wire logic       sdio_out,
  input  wire logic       sdio_oe,
  input  wire logic       sdo_out,
  input  wire logic       sdo_oe,
  output logic            rv,
  output logic [7:0]      rd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH = 6;
  logic h_d;
  // the device wins the shared wire while it drives it
  assign sdio_in = sdio_oe ? sdio_out : h_d;
  initial
  begin
    sclk_pin = 1'b0;
    csb_n_pin = 1'b1;
    h_d = 1'b0;
    rv = 1'b0;
    rd = 8'h00;
  end
  task automatic xfer(input logic rdn, input logic [12:0] a,
                      input logic [7:0] wd, input bit lsb, input bit sdo);
    logic [15:0] ins;
    logic [7:0]  rb;
    logic        w;
    ins = {rdn, 2'h0, a};
    rb = 8'h00;
    @(negedge clk_sys);
    csb_n_pin = 1'b0;
    repeat (PH) @(negedge clk_sys);
    for (int i = 23; i >= 0; i--)
    begin
      // a released line toggles so a stale level can never pass
      if (rdn && i < 8)
        h_d = ~h_d;
      else if (i >= 8)
        h_d = lsb ? ins[23-i] : ins[i-8];
      else
        h_d = lsb ? wd[7-i] : wd[i];
      repeat (PH) @(negedge clk_sys);
      w = sdo ? ((sdo_oe && !sdio_oe) ? sdo_out : 1'bx)
              : ((sdio_oe && !sdo_oe) ? sdio_out : 1'bx);
      if (i < 8)
        rb = lsb ? {w, rb[7:1]} : {rb[6:0], w};
      sclk_pin = 1'b1;
      repeat (PH) @(negedge clk_sys);
      sclk_pin = 1'b0;
    end
    repeat (PH) @(negedge clk_sys);
    csb_n_pin = 1'b1;
    repeat (PH) @(negedge clk_sys);
    if (rdn)
    begin
      rd = rb;
      rv = 1'b1;
      @(negedge clk_sys);
      rv = 1'b0;
    end
  endtask
endmodule

// ===== tb.sv
/*
  self-checking bench for cscr_regs: reset values, identifiers, channel
  selects, power decoding, shift order, data-out pin and soft reset.
  assumes cscr_host frames each transfer and reports read bytes.
*/
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PID = 8'hC3;  // arbitrary value
  localparam logic [7:0] GID = 8'h3C;  // arbitrary value
  logic       clk_sys, srst, sclk_pin, csb_n_pin, sdio_in, pwdn_pin;
  logic       sdio_out, sdio_oe, sdo_out, sdo_oe, lsb_first, rv, s_v;
  logic       function_bypass, pwr_full_down, pwr_standby;
  logic       pwr_core_down, pwr_afe_down, outputs_disabled;
  logic [7:0] conv_chan_en, aux_chan_en, rd, s_d, m;
  logic [7:0] exq[$];
  logic [31:0] seed, r;
  bit         lsb, sdo;
  int         n_errors, check_count;
  wire [7:0]  pwr = {2'h0, function_bypass, pwr_full_down, pwr_standby,
                     pwr_core_down, pwr_afe_down, outputs_disabled};
  cscr_regs #(.PART_ID(PID), .GRADE_ID(GID)) i_cscr_regs (
    .clk_sys(clk_sys), .srst(srst), .sclk_pin(sclk_pin),
    .csb_n_pin(csb_n_pin), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .pwdn_pin(pwdn_pin), .conv_chan_en(conv_chan_en),
    .aux_chan_en(aux_chan_en), .lsb_first(lsb_first),
    .function_bypass(function_bypass), .pwr_full_down(pwr_full_down),
    .pwr_standby(pwr_standby), .pwr_core_down(pwr_core_down),
    .pwr_afe_down(pwr_afe_down), .outputs_disabled(outputs_disabled));
  cscr_host i_cscr_host (
    .clk_sys(clk_sys), .sclk_pin(sclk_pin), .csb_n_pin(csb_n_pin),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .rv(rv), .rd(rd));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    repeat (32) seed = {seed[30:0], seed[31]^seed[21]^seed[1]^seed[0]};
    return seed;
  endfunction
  // ext field wins only while enabled and the pin is asserted
  function automatic logic [7:0] pexp(input logic [7:0] v, input logic p);
    logic [4:0] o;
    o = 5'h00;
    if (v[7] && p)
      o = (v[6:5] == 2'h0) ? 5'h10 : (v[6:5] == 2'h1) ? 5'h08 :
          (v[6:5] == 2'h2) ? 5'h01 : 5'h00;
    else
      o = (v[2:0] == 3'h1) ? 5'h10 : (v[2:0] == 3'h2) ? 5'h08 :
          (v[2:0] == 3'h4) ? 5'h04 : (v[2:0] == 3'h5) ? 5'h02 : 5'h00;
    return {2'h0, v[3], o};
  endfunction
  task automatic cmp(input logic [7:0] got);
    logic [7:0] e;
    e = (exq.size() > 0) ? exq.pop_front() : 8'hXX;
    `CHK(got, e)
  endtask
  always @(posedge clk_sys)
  begin
    if (rv === 1'b1)
      cmp(rd);
    if (s_v === 1'b1)
      cmp(s_d);
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    i_cscr_host.xfer(1'b0, a, d, lsb, sdo);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    exq.push_back(e);
    i_cscr_host.xfer(1'b1, a, 8'h00, lsb, sdo);
  endtask
  task automatic look(input logic [7:0] got, input logic [7:0] e);
    @(negedge clk_sys);
    exq.push_back(e);
    s_d = got;
    s_v = 1'b1;
    @(negedge clk_sys);
    s_v = 1'b0;
  endtask
  task automatic done_t(input string n);
    $display("test %s done", n);
  endtask
  task automatic results();
    // an expected value that never showed up is a miss as well
    if (exq.size() != 0)
      n_errors++;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  initial
  begin
    srst = 1'b1;
    pwdn_pin = 1'b0;
    s_v = 1'b0;
    s_d = 8'h00;
    seed = 32'h7E724F9F;
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    repeat (6) @(negedge clk_sys);
    rdc(13'h0, 8'h18);
    rdc(13'h4, 8'hFF);
    rdc(13'h5, 8'hFF);
    rdc(13'h8, 8'h00);
    look(conv_chan_en, 8'hFF);
    look(aux_chan_en, 8'hFF);
    look({7'h00, lsb_first}, 8'h00);
    look(pwr, 8'h00);
    done_t("reset");
    r = rnd();
    wr(13'h1, r[7:0]);
    wr(13'h2, r[15:8]);
    wr(13'h3, r[23:16]);
    rdc(13'h1, PID);
    rdc(13'h2, GID);
    rdc(13'h3, 8'h00);
    done_t("identifiers");
    for (int i = 0; i < 3; i++)
    begin
      r = rnd();
      wr(13'h5, r[7:0]);
      wr(13'h4, r[15:8]);
      look(conv_chan_en, {r[11:8], r[3:0]});
      look(aux_chan_en, {r[15:12], r[7:4]});
      rdc(13'h5, r[7:0]);
      rdc(13'h4, r[15:8]);
    end
    done_t("channel select");
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      m = (i < 8) ? {r[7:3], i[2:0]} : {1'b1, i[1:0], r[4:0]};
      pwdn_pin = (i >= 8) || r[8];
      wr(13'h8, m);
      look(pwr, pexp(m, pwdn_pin));
      rdc(13'h8, m);
    end
    pwdn_pin = 1'b0;
    done_t("power modes");
    wr(13'h0, 8'h00);
    rdc(13'h0, 8'h18);
    wr(13'h0, 8'h5A);
    lsb = 1'b1;
    look({7'h00, lsb_first}, 8'h01);
    rdc(13'h0, 8'h5A);
    r = rnd();
    wr(13'h5, r[7:0]);
    rdc(13'h5, r[7:0]);
    rdc(13'h1, PID);
    wr(13'h0, 8'h18);
    lsb = 1'b0;
    look({7'h00, lsb_first}, 8'h00);
    done_t("shift order");
    wr(13'h0, 8'h99);
    sdo = 1'b1;
    rdc(13'h0, 8'h99);
    rdc(13'h5, r[7:0]);
    wr(13'h0, 8'h18);
    sdo = 1'b0;
    rdc(13'h0, 8'h18);
    done_t("data out pin");
    wr(13'h5, 8'h12);
    wr(13'h8, 8'h01);
    wr(13'h0, 8'h3C);
    rdc(13'h0, 8'h18);
    rdc(13'h5, 8'hFF);
    rdc(13'h8, 8'h00);
    look(conv_chan_en, 8'hFF);
    look(pwr, 8'h00);
    done_t("soft reset");
    results();
  end
endmodule
